// ===== design/cpu_instruction_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_datapath (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [11:0] i_instr,
  input  wire logic        i_instr_valid,
  input  wire logic [11:0] i_extended_config_word,
  input  wire logic        i_turbo_mode,
  output logic             o_exec_slot,
  output logic             o_retired,
  output logic             o_skipped,
  output logic [7:0]       o_accumulator,
  output logic             o_carry,
  output logic             o_zero,
  output logic [2:0]       o_bank_select,
  output logic [7:0]       o_result
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] file_mem [datapath_pkg::REGS];
  logic [7:0] accumulator;
  logic [2:0] bank_select_register;
  logic       carry_flag;
  logic       zero_flag;
  logic       carry_input_disable;
  logic       turbo;
  logic       cfg_loaded;
  logic [1:0] div_cnt;
  logic       cycle_en;
  logic       skip_pending;

  alu_if alu ();

  datapath_alu u_alu (
    .bus (alu)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic [4:0] fr_field(input logic [11:0] ins);
    fr_field = ins[4:0];
  endfunction : fr_field

  wire [3:0] grp        = i_instr[11:8];
  wire [1:0] sub_op     = i_instr[7:6];
  wire       dest_f     = i_instr[5];
  wire [4:0] file_register_operand = fr_field(i_instr);
  wire [7:0] imm        = i_instr[7:0];
  wire [7:0] file_addr  = {bank_select_register, file_register_operand};
  wire [7:0] file_rd    = file_mem[file_addr];

  wire is_imm   = (grp == datapath_pkg::GRP_MOVL) | (grp == datapath_pkg::GRP_ORL)
                | (grp == datapath_pkg::GRP_ANDL) | (grp == datapath_pkg::GRP_XORL);
  wire is_nop   = (i_instr == datapath_pkg::OPC_NOP);
  wire is_clrw  = (i_instr == datapath_pkg::OPC_CLRW);
  wire is_bank  = (i_instr[11:3] == datapath_pkg::OPC_BANK);
  wire is_movwf = (grp == datapath_pkg::GRP_MISC) & (sub_op == 2'h0) & dest_f;
  wire is_clrf  = (grp == datapath_pkg::GRP_MISC) & (sub_op == 2'h1) & dest_f;
  wire is_sub   = (grp == datapath_pkg::GRP_MISC) & (sub_op == 2'h2);
  wire is_dec   = (grp == datapath_pkg::GRP_MISC) & (sub_op == 2'h3);
  wire is_decsz = (grp == datapath_pkg::GRP_UNARY) & (sub_op == 2'h3);
  wire is_incsz = (grp == datapath_pkg::GRP_SHIFT) & (sub_op == 2'h3);
  wire is_fileop = (grp == datapath_pkg::GRP_LOGIC) | (grp == datapath_pkg::GRP_UNARY)
                 | (grp == datapath_pkg::GRP_SHIFT) | is_sub | is_dec;

  // Unlisted codes retire as no operation
  wire writes_w = is_imm | is_clrw | (is_fileop & ~dest_f);
  wire writes_f = is_movwf | is_clrf | (is_fileop & dest_f);
  wire test_op  = is_decsz | is_incsz;

  datapath_pkg::alu_op_t next_op;

  always_comb
  begin
    next_op = datapath_pkg::ALU_PASS_F;
    unique case (grp)
      datapath_pkg::GRP_MISC:
        if (is_movwf)
          next_op = datapath_pkg::ALU_PASS_W;
        else if (is_sub)
          next_op = datapath_pkg::ALU_SUB;
        else if (is_dec)
          next_op = datapath_pkg::ALU_DEC;
        else
          next_op = datapath_pkg::ALU_CLR;
      datapath_pkg::GRP_LOGIC:
        unique case (sub_op)
          2'h0:    next_op = datapath_pkg::ALU_OR;
          2'h1:    next_op = datapath_pkg::ALU_AND;
          2'h2:    next_op = datapath_pkg::ALU_XOR;
          default: next_op = datapath_pkg::ALU_ADD;
        endcase
      datapath_pkg::GRP_UNARY:
        unique case (sub_op)
          2'h0:    next_op = datapath_pkg::ALU_PASS_F;
          2'h1:    next_op = datapath_pkg::ALU_NOT;
          2'h2:    next_op = datapath_pkg::ALU_INC;
          default: next_op = datapath_pkg::ALU_DEC;
        endcase
      datapath_pkg::GRP_SHIFT:
        unique case (sub_op)
          2'h0:    next_op = datapath_pkg::ALU_RR;
          2'h1:    next_op = datapath_pkg::ALU_RL;
          2'h2:    next_op = datapath_pkg::ALU_SWAP;
          default: next_op = datapath_pkg::ALU_INC;
        endcase
      datapath_pkg::GRP_MOVL: next_op = datapath_pkg::ALU_PASS_F;
      datapath_pkg::GRP_ORL:  next_op = datapath_pkg::ALU_OR;
      datapath_pkg::GRP_ANDL: next_op = datapath_pkg::ALU_AND;
      datapath_pkg::GRP_XORL: next_op = datapath_pkg::ALU_XOR;
      default:                next_op = datapath_pkg::ALU_PASS_F;
    endcase
  end

  assign alu.op            = next_op;
  assign alu.opnd_f        = is_imm ? imm : file_rd;
  assign alu.opnd_w        = accumulator;
  assign alu.carry_in      = carry_flag;
  assign alu.carry_disable = carry_input_disable;

  // ****************************************************************
  // Execute strobes
  // ****************************************************************
  wire execute  = cycle_en & i_instr_valid;
  wire squash   = execute & skip_pending;
  wire commit   = execute & ~skip_pending & ~is_nop;
  wire skip_set = commit & test_op & alu.zero;
  wire next_cycle_en = turbo | (div_cnt == datapath_pkg::DIV_LAST);

  // ****************************************************************
  // Configuration capture
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      cfg_loaded          <= 1'b0;
      carry_input_disable <= datapath_pkg::RST_CARRY_DISABLE;
      turbo               <= datapath_pkg::RST_TURBO;
    end
    else if (!cfg_loaded)
    begin
      cfg_loaded          <= 1'b1;
      carry_input_disable <= i_extended_config_word[datapath_pkg::CFG_CARRY_POS];
      turbo               <= i_turbo_mode;
    end
  end

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      div_cnt  <= datapath_pkg::RST_DIV;
      cycle_en <= 1'b0;
    end
    else
    begin
      div_cnt  <= (turbo | !cfg_loaded) ? datapath_pkg::RST_DIV : div_cnt + 2'h1;
      cycle_en <= cfg_loaded & next_cycle_en;
    end
  end

  // ****************************************************************
  // Architectural registers
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      accumulator          <= datapath_pkg::RST_DATA;
      bank_select_register <= datapath_pkg::RST_BANK;
      carry_flag           <= 1'b0;
      zero_flag            <= 1'b0;
      skip_pending         <= 1'b0;
    end
    else
    begin
      if (execute)
        skip_pending <= skip_set;
      if (commit & writes_w)
        accumulator <= alu.result;
      if (commit & is_bank)
        bank_select_register <= i_instr[2:0];
      if (commit & alu.carry_upd & (writes_w | writes_f))
        carry_flag <= alu.carry_out;
      if (commit & (writes_w | writes_f) & ~is_movwf)
        zero_flag <= alu.zero;
    end
  end

  // No reset on the data file
  always_ff @(posedge i_clk_sys)
  begin
    if (commit & writes_f)
      file_mem[file_addr] <= alu.result;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_exec_slot   <= 1'b0;
      o_retired     <= 1'b0;
      o_skipped     <= 1'b0;
      o_accumulator <= datapath_pkg::RST_DATA;
      o_carry       <= 1'b0;
      o_zero        <= 1'b0;
      o_bank_select <= datapath_pkg::RST_BANK;
      o_result      <= datapath_pkg::RST_DATA;
    end
    else
    begin
      o_exec_slot   <= cfg_loaded & next_cycle_en;
      o_retired     <= execute & ~skip_pending;
      o_skipped     <= squash;
      o_accumulator <= (commit & writes_w) ? alu.result : accumulator;
      o_carry       <= (commit & alu.carry_upd & (writes_w | writes_f)) ? alu.carry_out
                                                                        : carry_flag;
      o_zero        <= (commit & (writes_w | writes_f) & ~is_movwf) ? alu.zero : zero_flag;
      o_bank_select <= (commit & is_bank) ? i_instr[2:0] : bank_select_register;
      if (commit)
        o_result <= alu.result;
    end
  end

endmodule : cpu_instruction_datapath
`default_nettype wire

// ===== design/datapath_pkg.sv
package datapath_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int INSTR_W = 12;
  localparam int DATA_W  = 8;
  localparam int FR_W    = 5;
  localparam int BANK_W  = 3;
  localparam int REGS    = 256;

  // ****************************************************************
  // Configuration bit positions and reset values
  // ****************************************************************
  localparam int CFG_CARRY_POS = 6;
  localparam logic RST_CARRY_DISABLE = 1'b1;
  localparam logic RST_TURBO         = 1'b1;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [2:0] RST_BANK    = 3'h0;
  localparam logic [1:0] RST_DIV     = 2'h0;

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  localparam int COMPAT_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(COMPAT_DIV - 2);

  // ****************************************************************
  // Opcode groups, top bits of the instruction
  // ****************************************************************
  localparam logic [3:0] GRP_MISC = 4'h0;
  localparam logic [3:0] GRP_LOGIC = 4'h1;
  localparam logic [3:0] GRP_UNARY = 4'h2;
  localparam logic [3:0] GRP_SHIFT = 4'h3;
  localparam logic [3:0] GRP_MOVL = 4'hc;
  localparam logic [3:0] GRP_ORL  = 4'hd;
  localparam logic [3:0] GRP_ANDL = 4'he;
  localparam logic [3:0] GRP_XORL = 4'hf;

  localparam logic [11:0] OPC_NOP  = 12'h000;
  localparam logic [11:0] OPC_CLRW = 12'h040;
  localparam logic [8:0]  OPC_BANK = 9'h003;

  // ****************************************************************
  // ALU operations
  // ****************************************************************
  typedef enum logic [4:0] {
    ALU_PASS_W = 5'h00, ALU_PASS_F = 5'h01, ALU_CLR  = 5'h02,
    ALU_SUB    = 5'h03, ALU_DEC    = 5'h04, ALU_OR   = 5'h05,
    ALU_AND    = 5'h06, ALU_XOR    = 5'h07, ALU_ADD  = 5'h08,
    ALU_NOT    = 5'h09, ALU_INC    = 5'h0a, ALU_RR   = 5'h0b,
    ALU_RL     = 5'h0c, ALU_SWAP   = 5'h0d
  } alu_op_t;

endpackage : datapath_pkg

// ===== design/alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  datapath_pkg::alu_op_t op;
  logic [7:0]            opnd_f;
  logic [7:0]            opnd_w;
  logic                  carry_in;
  logic                  carry_disable;
  logic [7:0]            result;
  logic                  carry_out;
  logic                  carry_upd;
  logic                  zero;

  modport core (output op, opnd_f, opnd_w, carry_in, carry_disable,
                input result, carry_out, carry_upd, zero);
  modport unit (input op, opnd_f, opnd_w, carry_in, carry_disable,
                output result, carry_out, carry_upd, zero);
endinterface : alu_if
`default_nettype wire

// ===== design/datapath_alu.sv
`timescale 1ns/1ps
`default_nettype none
module datapath_alu (
  alu_if.unit bus
);

  // ****************************************************************
  // Carry feed into add and subtract
  // ****************************************************************
  wire       add_cin = bus.carry_disable ? 1'b0 : bus.carry_in;
  wire       sub_bin = bus.carry_disable ? 1'b0 : ~bus.carry_in;
  wire [8:0] sum     = {1'b0, bus.opnd_f} + {1'b0, bus.opnd_w} + {8'h00, add_cin};
  wire [8:0] diff    = {1'b0, bus.opnd_f} - {1'b0, bus.opnd_w} - {8'h00, sub_bin};

  always_comb
  begin
    bus.result    = bus.opnd_f;
    bus.carry_out = bus.carry_in;
    bus.carry_upd = 1'b0;
    unique case (bus.op)
      datapath_pkg::ALU_PASS_W: bus.result = bus.opnd_w;
      datapath_pkg::ALU_PASS_F: bus.result = bus.opnd_f;
      datapath_pkg::ALU_CLR:    bus.result = 8'h00;
      datapath_pkg::ALU_OR:     bus.result = bus.opnd_f | bus.opnd_w;
      datapath_pkg::ALU_AND:    bus.result = bus.opnd_f & bus.opnd_w;
      datapath_pkg::ALU_XOR:    bus.result = bus.opnd_f ^ bus.opnd_w;
      datapath_pkg::ALU_NOT:    bus.result = ~bus.opnd_f;
      datapath_pkg::ALU_INC:    bus.result = bus.opnd_f + 8'h01;
      datapath_pkg::ALU_DEC:    bus.result = bus.opnd_f - 8'h01;
      datapath_pkg::ALU_SWAP:   bus.result = {bus.opnd_f[3:0], bus.opnd_f[7:4]};
      datapath_pkg::ALU_ADD:
      begin
        bus.result    = sum[7:0];
        bus.carry_out = sum[8];
        bus.carry_upd = 1'b1;
      end
      datapath_pkg::ALU_SUB:
      begin
        bus.result    = diff[7:0];
        bus.carry_out = ~diff[8];
        bus.carry_upd = 1'b1;
      end
      datapath_pkg::ALU_RR:
      begin
        bus.result    = {bus.carry_in, bus.opnd_f[7:1]};
        bus.carry_out = bus.opnd_f[0];
        bus.carry_upd = 1'b1;
      end
      datapath_pkg::ALU_RL:
      begin
        bus.result    = {bus.opnd_f[6:0], bus.carry_in};
        bus.carry_out = bus.opnd_f[7];
        bus.carry_upd = 1'b1;
      end
      default:                  bus.result = bus.opnd_f;
    endcase
    bus.zero = (bus.result == 8'h00);
  end

endmodule : datapath_alu
`default_nettype wire

// ===== testbench/cpu_datapath_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_datapath_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic [11:0] i_instr,
  input wire logic        i_instr_valid,
  input wire logic [11:0] i_extended_config_word,
  input wire logic        i_turbo_mode,
  input wire logic        o_exec_slot,
  input wire logic        o_retired,
  input wire logic        o_skipped,
  input wire logic [7:0]  o_accumulator,
  input wire logic        o_carry,
  input wire logic        o_zero,
  input wire logic [2:0]  o_bank_select,
  input wire logic [7:0]  o_result
);
  // ****************
  // Mode capture
  // ****************
  logic cap_done;
  logic turbo_cap;
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      cap_done  <= 1'b0;
      turbo_cap <= 1'b1;
    end
    else if (!cap_done)
    begin
      cap_done  <= 1'b1;
      turbo_cap <= i_turbo_mode;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  AST_TURBO_SLOT: assert property (turbo_cap && o_exec_slot |=> o_exec_slot)
    else $error("slot lost in turbo mode");
  AST_COMPAT_SLOT: assert property (
    !turbo_cap && o_exec_slot |=> !o_exec_slot [*3] ##1 o_exec_slot)
    else $error("compatible slot spacing not four");
  AST_TAKE_ANSWER: assert property (
    o_exec_slot && i_instr_valid |=> o_retired || o_skipped)
    else $error("taken word gave no pulse");
  AST_IDLE: assert property (
    !(o_exec_slot && i_instr_valid) |=> !o_retired && !o_skipped)
    else $error("pulse without a taken word");
  AST_EXCL: assert property (!(o_retired && o_skipped))
    else $error("retired and skipped together");
  AST_MOV_LIT: assert property (
    o_retired && $past(i_instr[11:8]) == 4'hc |-> o_accumulator == $past(i_instr[7:0]))
    else $error("literal move wrong");
  AST_AND_LIT: assert property (
    o_retired && $past(i_instr[11:8]) == 4'he
    |-> o_accumulator == ($past(o_accumulator) & $past(i_instr[7:0])))
    else $error("literal and wrong");
  AST_XOR_LIT: assert property (
    o_retired && $past(i_instr[11:8]) == 4'hf
    |-> o_accumulator == ($past(o_accumulator) ^ $past(i_instr[7:0])))
    else $error("literal xor wrong");
  AST_ZERO_LIT: assert property (
    o_retired && $past(i_instr[11:10]) == 2'h3 |-> o_zero == (o_accumulator == 8'h00))
    else $error("zero flag wrong");
  AST_BANK: assert property (
    o_retired && $past(i_instr[11:3]) == 9'h003 |-> o_bank_select == $past(i_instr[2:0]))
    else $error("bank select not loaded");
  AST_SKIP: assert property (
    o_retired && $past(i_instr[11:6]) inside {6'h0f, 6'h0b} && o_result == 8'h00
    |-> ##[1:4] o_skipped)
    else $error("zero test did not skip");
  cover property (o_skipped);
  cover property (!turbo_cap && o_exec_slot);
  cover property (o_retired && o_bank_select != 3'h0);
endmodule : cpu_datapath_checker
bind cpu_instruction_datapath cpu_datapath_checker u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_turbo_mode(i_turbo_mode),
  .i_extended_config_word(i_extended_config_word), .o_exec_slot(o_exec_slot),
  .o_retired(o_retired), .o_skipped(o_skipped), .o_accumulator(o_accumulator),
  .o_carry(o_carry), .o_zero(o_zero), .o_bank_select(o_bank_select), .o_result(o_result));
`default_nettype wire

// ===== testbench/prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem (
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  input  wire logic   i_exec_slot,
  input  wire logic   i_run,
  output var logic [11:0] o_instr,
  output var logic    o_instr_valid
);
  // ****************
  // Word feed
  // ****************
  logic [11:0] rom [0:31];
  int          len = 0;
  int          pc = 0;
  logic        taken = 1'b0;
  logic [11:0] last_word = 12'h000;
  initial o_instr = 12'h000;
  initial o_instr_valid = 1'b0;
  always @(posedge i_clk_sys) taken <= i_exec_slot && o_instr_valid;
  // Advance away from the sampling edge
  always @(negedge i_clk_sys)
  begin
    if (i_reset || !i_run)
      pc = 0;
    else if (taken)
      pc = pc + 1;
    o_instr_valid = i_run && !i_reset && pc < len;
    if (o_instr_valid)
      last_word = rom[pc];
    // Released bus holds the inverse of the last word
    o_instr = o_instr_valid ? last_word : ~last_word;
  end
endmodule : prog_mem
`default_nettype wire

// ===== testbench/test_cpu_instruction_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_instruction_datapath;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0;
  logic        turbo = 1'b1;
  logic [11:0] cfg = 12'h040;
  logic [11:0] instr;
  logic        valid, slot, retired, skipped, carry, zero;
  logic [7:0]  acc, result;
  logic [2:0]  bank;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          skip_n = 0;
  logic [7:0]  res_q[$];
  int          t_q[$];
  // ****************
  // Harness
  // ****************
  cpu_instruction_datapath DUT (.i_clk_sys(clk), .i_reset(rst), .i_instr(instr),
    .i_instr_valid(valid), .i_extended_config_word(cfg), .i_turbo_mode(turbo),
    .o_exec_slot(slot), .o_retired(retired), .o_skipped(skipped), .o_accumulator(acc),
    .o_carry(carry), .o_zero(zero), .o_bank_select(bank), .o_result(result));
  prog_mem pm (.i_clk_sys(clk), .i_reset(rst), .i_exec_slot(slot), .i_run(run),
    .o_instr(instr), .o_instr_valid(valid));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (retired)
    begin
      res_q.push_back(result);
      t_q.push_back(cyc);
    end
    if (skipped)
      skip_n++;
  end
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task start(input logic [11:0] c, input logic t);
    @(negedge clk);
    rst = 1'b1;
    cfg = c;
    turbo = t;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : start
  task run_prog(input logic [11:0] p[$], input int exp[$]);
    int n;
    n = 0;
    foreach (p[i]) pm.rom[i] = p[i];
    pm.len = p.size();
    res_q.delete();
    t_q.delete();
    skip_n = 0;
    // Let the feed see run low once so its counter restarts
    repeat (2) @(negedge clk);
    run = 1'b1;
    while (res_q.size() < exp.size() && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    run = 1'b0;
    check("count", 8'(exp.size()), 8'(res_q.size()));
    foreach (exp[i]) if (exp[i] >= 0 && i < res_q.size()) check("result", 8'(exp[i]), res_q[i]);
  endtask : run_prog
  // ****************
  // Scenarios
  // ****************
  task logic_ops;
    run_prog('{12'hc5a, 12'he0f, 12'hd30, 12'hfff, 12'h021, 12'h261, 12'h141, 12'h101,
      12'h1a1, 12'h000, 12'h4a5},
      '{'h5a, 'h0a, 'h3a, 'hc5, -1, 'h3a, 'h00, 'h3a, 'h00, -1, -1});
    check("zero", 8'h01, {7'h0, zero});
    check("acc", 8'h3a, acc);
    check("spacing", 8'h06, 8'(t_q[6] - t_q[0]));
  endtask : logic_ops
  task arith_ignore;
    run_prog('{12'hcf0, 12'h022, 12'hc20, 12'h1e2, 12'h1e2, 12'h0a2, 12'h0a2, 12'h0a2,
      12'h322, 12'h362, 12'h3a2, 12'h2a2, 12'h0e2, 12'h062, 12'h040},
      '{'hf0, -1, 'h20, 'h10, 'h30, 'h10, 'hf0, 'hd0, 'he8, 'hd0, 'h0d, 'h0e, 'h0d, 0, 0});
    check("zero", 8'h01, {7'h0, zero});
    check("carry", 8'h01, {7'h0, carry});
  endtask : arith_ignore
  task arith_carry;
    cfg = 12'h040;
    run_prog('{12'hcff, 12'h023, 12'h1e3, 12'h1e3, 12'hc01, 12'h0a3, 12'hcff, 12'h0a3, 12'h0a3},
      '{'hff, -1, 'hfe, 'hfe, 'h01, 'hfd, 'hff, 'hfe, 'hfe});
    check("carry", 8'h00, {7'h0, carry});
  endtask : arith_carry
  task skip_ops;
    run_prog('{12'hcff, 12'h024, 12'h3e4, 12'hc11, 12'hc22, 12'h2e4, 12'hc33, 12'hc01,
      12'h024, 12'h2e4, 12'hc44, 12'hc55},
      '{'hff, -1, 'h00, 'h22, 'hff, 'h33, 'h01, -1, 'h00, 'h55});
    check("skips", 8'h02, 8'(skip_n));
    check("span", 8'h0b, 8'(t_q[9] - t_q[0]));
    check("acc", 8'h55, acc);
  endtask : skip_ops
  task bank_ops;
    run_prog('{12'h018, 12'hc11, 12'h021, 12'h01d, 12'hc77, 12'h021, 12'h018, 12'h201,
      12'h01d, 12'h201}, '{-1, 'h11, -1, -1, 'h77, -1, -1, 'h11, -1, 'h77});
    check("bank", 8'h05, {5'h0, bank});
    check("acc", 8'h77, acc);
  endtask : bank_ops
  task compat_ops;
    run_prog('{12'hc12, 12'he10, 12'hd01}, '{'h12, 'h10, 'h11});
    check("gap", 8'h04, 8'(t_q[1] - t_q[0]));
    check("gap", 8'h04, 8'(t_q[2] - t_q[1]));
  endtask : compat_ops
  task close_out;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  initial
  begin
    start(12'h040, 1'b1);
    logic_ops();
    arith_ignore();
    skip_ops();
    bank_ops();
    start(12'h000, 1'b1);
    arith_carry();
    start(12'h040, 1'b0);
    compat_ops();
    close_out();
  end
  initial
  begin
    #40000;
    err_count++;
    close_out();
  end
endmodule : test_cpu_instruction_datapath
`default_nettype wire
